// *** design/rsq_sequencer.sv ***
`default_nettype none
// Notes on behaviour
// - Internal reset request drives reset pin low at least 512 cycles.
// - Request still active after 512 keeps pin low until it drops.
// - Power-on asserts master and external reset lines together.
// - After power-on hold pin until PLL lock plus 512 cycles.
// - Module reset only after master line held four running cycles.
// - Three-state input floats all outputs after about 10 cycles held.
// - External clock mode counts 10 oscillator pulses before floating.
// - Three-state state is left only by power-down.
// - Weak pull-ups during reset; low line selects alternate setting.
// - Boot select width 8 bits when data 0 low, else 16.
// - Boot select active at release, mapped from address zero.
// - Data 1 low gives bus arbitration pins; data 2 low function codes.
// - Data line N low makes chip selects 6 to N+3 upper address.
// - Data 8 low turns bus control pins into port E.
// - Data 9 low turns interrupt and clock mode pins into port F.
// - Data 11 low enables factory test mode.
// - First bus cycle 14 cycles after release of reset.
// - Clock mode high selects VCO, low selects external clock.
// - Any breakpoint low at release sets background debug flag.
// - Both breakpoints high gives breakpoint exception handling.
// - After drive, float pin 10 cycles then latch and test.
module rsq_sequencer
#(
	parameter int DRIVE_CYC   = rsq_pkg::RSQ_DRIVE_CYC,
	parameter int RELEASE_CYC = rsq_pkg::RSQ_RELEASE_CYC
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// Reset requests and clock status
	input  wire logic            int_reset_req,
	input  wire logic            pll_locked,
	input  wire logic            ext_osc_input,
	// Reset pin, open drain
	input  wire logic            reset_pin_in,
	output logic                 reset_pin_out,
	output logic                 reset_pin_oe_n,
	// Mode pins
	input  wire logic [15:0]     data_in,
	output logic                 data_pullup_en,
	input  wire logic            clock_mode_select,
	input  wire logic [1:0]      breakpoint_request,
	input  wire logic            three_state_control,
	// Reset lines
	output logic                 master_reset_line,
	output logic                 external_reset_line,
	output logic                 module_reset,
	output logic                 outputs_hiz,
	// Configuration and sequencing
	output rsq_pkg::rsq_cfg_t    cfg,
	output logic [23:0]          boot_base_addr,
	output logic                 boot_cs_active,
	output logic                 first_bus_cycle,
	output logic                 breakpoint_request_to_background,
	output logic                 breakpoint_request_to_exception
);
	import rsq_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [15:0] data_s;
	logic [5:0]  ctl_s;
	logic        rst_pin_s;
	logic        int_req_s;
	logic        pll_s;
	logic        osc_s;
	logic        tsc_s;
	logic        mod_s;
	logic [1:0]  breakpoint_request_s;

	rsq_sync #(.W(16), .RST(RSQ_DATA_RST)) u_data_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (data_in),
		.q       (data_s)
	);

	// Control pins; reset pin sync resets asserted
	rsq_sync #(.W(6), .RST(6'h07)) u_ctl_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({ext_osc_input, three_state_control, pll_locked,
		           clock_mode_select, breakpoint_request}),
		.q       (ctl_s)
	);

	rsq_sync #(.W(2), .RST(2'h0)) u_rst_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({reset_pin_in, int_reset_req}),
		.q       ({rst_pin_s, int_req_s})
	);

	assign osc_s  = ctl_s[5];
	assign tsc_s  = ctl_s[4];
	assign pll_s  = ctl_s[3];
	assign mod_s  = ctl_s[2];
	assign breakpoint_request_s = ctl_s[1:0];

	// ==========================================================
	// Sequencer state
	rsq_state_t            state_ff;
	rsq_state_t            nxt_state;
	logic [RSQ_CNT_W-1:0]  cnt_ff;
	logic [RSQ_CNT_W-1:0]  nxt_cnt;
	logic                  por_done_ff;
	logic [2:0]            ext_lo_ff;
	logic                  ext_req;
	logic                  drive_done;
	logic                  rel_done;
	logic [3:0]            tsc_cnt_ff;
	logic                  osc_d_ff;
	logic                  tsc_tick;
	logic                  tsc_hit;
	logic [4:0]            post_cnt_ff;

	// External low seen four cycles; our own drive is not counted
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_lo_ff <= 3'h0;
		end else if (!rst_pin_s && state_ff == RSQ_RUN) begin
			if (ext_lo_ff != 3'(RSQ_EXT_MIN_CYC - 1)) begin
				ext_lo_ff <= ext_lo_ff + 3'h1;
			end
		end else begin
			ext_lo_ff <= 3'h0;
		end
	end
	assign ext_req = (ext_lo_ff == 3'(RSQ_EXT_MIN_CYC - 1)) && !rst_pin_s;

	assign drive_done = (cnt_ff == RSQ_CNT_W'(DRIVE_CYC - 1));
	assign rel_done   = (cnt_ff == RSQ_CNT_W'(RELEASE_CYC - 1));

	// Next state and counter
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + RSQ_CNT_W'(1);
		unique case (state_ff)
			RSQ_POR: begin
				// Count only once the PLL reports lock
				if (!pll_s) begin
					nxt_cnt = '0;
				end else if (drive_done) begin
					nxt_state = RSQ_RELEASE;
					nxt_cnt   = '0;
				end
			end
			RSQ_DRIVE: begin
				// Minimum drive, then hold while the internal request stays
				if (drive_done) begin
					nxt_cnt = cnt_ff;
					if (!int_req_s) begin
						nxt_state = RSQ_RELEASE;
						nxt_cnt   = '0;
					end
				end
			end
			RSQ_RELEASE: begin
				// Test pin at end of high-Z window
				if (rel_done) begin
					nxt_cnt   = '0;
					nxt_state = rst_pin_s ? RSQ_START : RSQ_DRIVE;
				end
			end
			RSQ_START: begin
				nxt_cnt   = '0;
				nxt_state = RSQ_RUN;
			end
			RSQ_RUN: begin
				nxt_cnt = '0;
				if (int_req_s || ext_req) begin
					nxt_state = RSQ_DRIVE;
				end
			end
			RSQ_TRISTATE: begin
				nxt_cnt = cnt_ff;
			end
			default: begin
				nxt_state = RSQ_POR;
				nxt_cnt   = '0;
			end
		endcase
		// Three-state overrides all; only power-down leaves it
		if (tsc_hit || state_ff == RSQ_TRISTATE) begin
			nxt_state = RSQ_TRISTATE;
			nxt_cnt   = cnt_ff;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= RSQ_POR;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// Power-on history, cleared only by power-down reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			por_done_ff <= 1'b0;
		end else if (state_ff == RSQ_START) begin
			por_done_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Three-state control timing
	// Clock tick is the system clock or the external oscillator edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_d_ff <= 1'b0;
		end else begin
			osc_d_ff <= osc_s;
		end
	end
	assign tsc_tick = cfg.clk_from_vco ? 1'b1 : (osc_s && !osc_d_ff);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tsc_cnt_ff <= 4'h0;
		end else if (!tsc_s) begin
			tsc_cnt_ff <= 4'h0;
		end else if (tsc_tick && tsc_cnt_ff != 4'(RSQ_TSC_CYC)) begin
			tsc_cnt_ff <= tsc_cnt_ff + 4'h1;
		end
	end
	assign tsc_hit = (tsc_cnt_ff == 4'(RSQ_TSC_CYC));
	assign outputs_hiz = (state_ff == RSQ_TRISTATE);

	// ==========================================================
	// Reset lines and pin
	assign external_reset_line = (state_ff == RSQ_POR) || (state_ff == RSQ_DRIVE);
	assign master_reset_line   = (state_ff == RSQ_POR) || (state_ff == RSQ_RELEASE);
	// Pin only pulled low or floated
	assign reset_pin_out  = 1'b0;
	assign reset_pin_oe_n = !external_reset_line || outputs_hiz;
	assign data_pullup_en = (state_ff != RSQ_RUN) && !outputs_hiz;

	// Module reset after master line held four cycles, at power-on only
	logic [2:0] mst_cnt_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mst_cnt_ff   <= 3'h0;
			module_reset <= 1'b0;
		end else if (master_reset_line && !por_done_ff) begin
			if (mst_cnt_ff != 3'(RSQ_MOD_HOLD_CYC)) begin
				mst_cnt_ff <= mst_cnt_ff + 3'h1;
			end
			module_reset <= (mst_cnt_ff == 3'(RSQ_MOD_HOLD_CYC));
		end else begin
			mst_cnt_ff   <= 3'h0;
			module_reset <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration latch at end of release window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= '{boot_16bit: 1'b1, bus_arb_pins: 1'b0, func_code_pins: 1'b0,
			         upper_addr_en: 5'h00, port_e_io: 1'b0, port_f_io: 1'b0,
			         test_mode: 1'b0, clk_from_vco: 1'b1,
			         background_debug_flag: 1'b0};
		end else if (state_ff == RSQ_RELEASE && rel_done && rst_pin_s) begin
			cfg.boot_16bit     <= data_s[RSQ_D_BOOT16];
			cfg.bus_arb_pins   <= !data_s[RSQ_D_BUSARB];
			cfg.func_code_pins <= !data_s[RSQ_D_FCODE];
			// Low line N enables its own and every lower address bit
			for (int i = 0; i < 5; i++) begin
				cfg.upper_addr_en[i] <= !(&data_s[RSQ_D_ADDR_LO+4 -: 5] >> i == 1'b1)
				                        && (data_s[RSQ_D_ADDR_LO+4 : RSQ_D_ADDR_LO]
				                            >> i) != 5'h1F >> i;
			end
			cfg.port_e_io      <= !data_s[RSQ_D_PORT_E_IO];
			cfg.port_f_io      <= !data_s[RSQ_D_PORT_F_IO];
			cfg.test_mode      <= !data_s[RSQ_D_TEST];
			if (!por_done_ff) begin
				cfg.clk_from_vco <= mod_s;
			end
			cfg.background_debug_flag <= !(&breakpoint_request_s);
		end
	end

	// Breakpoint routing after release
	assign breakpoint_request_to_background = cfg.background_debug_flag && !(&breakpoint_request_s) && (state_ff == RSQ_RUN);
	assign breakpoint_request_to_exception  = !cfg.background_debug_flag && !(&breakpoint_request_s) && (state_ff == RSQ_RUN);

	// Boot select live from release, mapped at zero
	assign boot_base_addr = RSQ_BOOT_BASE;
	assign boot_cs_active = (state_ff == RSQ_RUN);

	// First bus cycle strobe 14 cycles after release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			post_cnt_ff     <= 5'h00;
			first_bus_cycle <= 1'b0;
		end else if (state_ff == RSQ_RUN) begin
			if (post_cnt_ff != 5'(RSQ_FIRST_BUS)) begin
				post_cnt_ff <= post_cnt_ff + 5'h01;
			end
			first_bus_cycle <= (post_cnt_ff == 5'(RSQ_FIRST_BUS - 1));
		end else begin
			post_cnt_ff     <= 5'h00;
			first_bus_cycle <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	sequence s_drive_start;
		state_ff == RSQ_RUN ##1 state_ff == RSQ_DRIVE;
	endsequence

	a_drive_min_len: assert property (@(posedge clk) disable iff (!reset_n)
		s_drive_start |-> !reset_pin_oe_n [*8])
		else $error("reset pin drive ended early");
	a_drive_hold_req: assert property (@(posedge clk) disable iff (!reset_n)
		(state_ff == RSQ_DRIVE && drive_done && int_req_s) |=> state_ff == RSQ_DRIVE)
		else $error("drive ended while request held");
	a_por_lines: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == RSQ_POR |-> master_reset_line && external_reset_line)
		else $error("power-on lines not both asserted");
	a_por_pll_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(state_ff == RSQ_POR && !pll_s && !tsc_hit) |=> state_ff == RSQ_POR)
		else $error("left power-on without lock");
	a_never_high: assert property (@(posedge clk) disable iff (!reset_n)
		!reset_pin_oe_n |-> reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	a_tsc_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == RSQ_TRISTATE |=> outputs_hiz && $stable(state_ff))
		else $error("left three-state");
	a_tsc_enter: assert property (@(posedge clk) disable iff (!reset_n)
		tsc_hit |=> outputs_hiz)
		else $error("three-state not entered");
	// A fresh reset inside the window cancels the first bus cycle
	a_first_bus: assert property (@(posedge clk) disable iff (!reset_n || state_ff != RSQ_RUN)
		$rose(state_ff == RSQ_RUN) && !tsc_s |-> ##14 first_bus_cycle || outputs_hiz)
		else $error("first bus cycle mistimed");
	a_release_test: assert property (@(posedge clk) disable iff (!reset_n)
		(state_ff == RSQ_RELEASE && rel_done && !rst_pin_s && !tsc_hit)
		|=> state_ff == RSQ_DRIVE)
		else $error("low pin not retested");
endmodule
`default_nettype wire

// *** common/rsq_pkg.sv ***
`default_nettype none
package rsq_pkg;
	// ==========================================================
	// Timing counts in system clock cycles; three-state settle counts oscillator pulses in external clock mode
	localparam int RSQ_DRIVE_CYC    = 512;  // Reset pin low period
	localparam int RSQ_RELEASE_CYC  = 10;   // High-Z test window
	localparam int RSQ_EXT_MIN_CYC  = 4;    // External request capture
	localparam int RSQ_MOD_HOLD_CYC = 4;    // Master line before module reset
	localparam int RSQ_TSC_CYC      = 10;   // Three-state settle
	localparam int RSQ_FIRST_BUS    = 14;   // First bus cycle after release
	localparam int RSQ_CNT_W        = 10;

	// ==========================================================
	// Data bus field positions
	localparam int RSQ_D_BOOT16 = 0;
	localparam int RSQ_D_BUSARB = 1;
	localparam int RSQ_D_FCODE  = 2;
	localparam int RSQ_D_ADDR_LO = 3;
	localparam int RSQ_D_PORT_E_IO  = 8;
	localparam int RSQ_D_PORT_F_IO  = 9;
	localparam int RSQ_D_TEST   = 11;
	localparam logic [15:0] RSQ_DATA_RST = 16'hFFFF; // Pull-up default
	localparam logic [23:0] RSQ_BOOT_BASE = 24'h000000;

	// ==========================================================
	// Sequencer states, Gray from DRIVE through RELEASE and START to RUN
	typedef enum logic [2:0] {
		RSQ_POR     = 3'b000,
		RSQ_DRIVE   = 3'b001,
		RSQ_RELEASE = 3'b011,
		RSQ_START   = 3'b010,
		RSQ_RUN     = 3'b110,
		RSQ_TRISTATE = 3'b111
	} rsq_state_t;

	// ==========================================================
	// Latched configuration
	typedef struct packed {
		logic       boot_16bit;
		logic       bus_arb_pins;
		logic       func_code_pins;
		logic [4:0] upper_addr_en;  // Bit i: CS(6+i) becomes ADDR(19+i)
		logic       port_e_io;
		logic       port_f_io;
		logic       test_mode;
		logic       clk_from_vco;
		logic       background_debug_flag;
	} rsq_cfg_t;
endpackage
`default_nettype wire

// *** design/rsq_sync.sv ***
`default_nettype none
// ==========================================================
// Two-stage synchroniser for a bus of pin levels
module rsq_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	// First stage read only by the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= RST;
			q       <= RST;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// *** testbench/rsq_board.sv ***
`default_nettype none
// ==========================================================
// Board-side reset and mode-select conditioning
module rsq_board #(
	parameter int LOCK_CYC = 30
) (
	// Clock and power
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Scenario controls
	input  wire logic [15:0] pull_low,
	input  wire logic        ext_hold,
	input  wire logic        osc_run,
	// Device pins
	input  wire logic        reset_pin_out,
	input  wire logic        reset_pin_oe_n,
	input  wire logic        data_pullup_en,
	output logic             reset_pin_in,
	output logic [15:0]      data_in,
	output logic             pll_locked,
	output logic             ext_osc_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int          lock_cnt;
	logic [15:0] junk;

	// PLL lock, oscillator pulses and released-bus noise
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_cnt <= 0;
			pll_locked <= 1'b0;
			ext_osc_input <= 1'b0;
			junk <= 16'h5A5A;
		end else begin
			lock_cnt <= #1 lock_cnt + 1;
			pll_locked <= #1 (lock_cnt >= LOCK_CYC);
			ext_osc_input <= #1 osc_run ? ~ext_osc_input : 1'b0; // Still outside use
			junk <= #1 ~junk;
		end
	end

	// Open-drain pin with pull-up; we may hold it low ourselves
	assign reset_pin_in = ext_hold ? 1'b0 : (!reset_pin_oe_n ? reset_pin_out : 1'b1);
	// Mode lines held only during reset, released before first bus cycle
	assign data_in = data_pullup_en ? ~pull_low : junk;
endmodule
`default_nettype wire

// *** testbench/tb_rsq_sequencer.sv ***
`default_nettype none
module tb_rsq_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import rsq_pkg::*;
	localparam int DRV  = 16;
	localparam int REL  = 10;
	localparam int LOCK = 30;
	logic        clk, reset_n, int_reset_req, clock_mode_select, three_state_control;
	logic        pll_locked, ext_osc_input, reset_pin_in, reset_pin_out, reset_pin_oe_n;
	logic        data_pullup_en, master_reset_line, external_reset_line, module_reset;
	logic        outputs_hiz, boot_cs_active, first_bus_cycle;
	logic        breakpoint_request_to_background, breakpoint_request_to_exception, ext_hold, osc_run;
	logic [1:0]  breakpoint_request;
	logic [15:0] data_in, pull_low;
	logic [23:0] boot_base_addr;
	rsq_cfg_t    cfg;
	int          error_cnt, checks_done;

	// ==========================================================
	// Design and board
	rsq_sequencer #(.DRIVE_CYC(DRV), .RELEASE_CYC(REL)) dut_u (
		.clk(clk), .reset_n(reset_n), .int_reset_req(int_reset_req),
		.pll_locked(pll_locked), .ext_osc_input(ext_osc_input),
		.reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
		.reset_pin_oe_n(reset_pin_oe_n), .data_in(data_in),
		.data_pullup_en(data_pullup_en), .clock_mode_select(clock_mode_select),
		.breakpoint_request(breakpoint_request), .three_state_control(three_state_control),
		.master_reset_line(master_reset_line), .external_reset_line(external_reset_line),
		.module_reset(module_reset), .outputs_hiz(outputs_hiz), .cfg(cfg),
		.boot_base_addr(boot_base_addr), .boot_cs_active(boot_cs_active),
		.first_bus_cycle(first_bus_cycle), .breakpoint_request_to_background(breakpoint_request_to_background),
		.breakpoint_request_to_exception(breakpoint_request_to_exception));
	rsq_board #(.LOCK_CYC(LOCK)) board_u (
		.clk(clk), .reset_n(reset_n), .pull_low(pull_low), .ext_hold(ext_hold),
		.osc_run(osc_run), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
		.data_pullup_en(data_pullup_en), .reset_pin_in(reset_pin_in), .data_in(data_in),
		.pll_locked(pll_locked), .ext_osc_input(ext_osc_input));

	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs move 1 ns after the edge, away from sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Count pin-driven cycles, then cycles until running again
	task automatic to_run(output int low_n, output int rel_n);
		low_n = 0;
		rel_n = 0;
		while (reset_pin_oe_n !== 1'b1 && low_n < 3000) begin
			cyc(1);
			low_n++;
		end
		while (boot_cs_active !== 1'b1 && rel_n < 3000) begin
			cyc(1);
			rel_n++;
		end
		// A limit that runs out is a hang, counted as a mismatch
		check(low_n < 3000 && rel_n < 3000, 1'b1);
	endtask

	function automatic rsq_cfg_t exp_cfg(input logic [15:0] d, input logic cm,
			input logic [1:0] bk);
		rsq_cfg_t c;
		c = '0;
		c.boot_16bit = d[0];
		c.bus_arb_pins = ~d[1];
		c.func_code_pins = ~d[2];
		for (int i = 0; i < 5; i++) begin
			for (int j = i; j < 5; j++) begin
				if (!d[3+j]) c.upper_addr_en[i] = 1'b1;
			end
		end
		c.port_e_io = ~d[8];
		c.port_f_io = ~d[9];
		c.test_mode = ~d[11];
		c.clk_from_vco = cm;
		c.background_debug_flag = ~&bk;
		return c;
	endfunction

	task automatic wrap_up();
		$display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog; whole run is a few hundred cycles
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200us;
		error_cnt++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		int lo, rl, n;
		error_cnt = 0;
		checks_done = 0;
		reset_n = 1'b0;
		int_reset_req = 1'b0;
		clock_mode_select = 1'b1;
		three_state_control = 1'b0;
		breakpoint_request = 2'b10;
		pull_low = 16'h0925;
		ext_hold = 1'b0;
		osc_run = 1'b0;
		cyc(16);
		check(master_reset_line, 1'b1);
		check(external_reset_line, 1'b1);
		check({reset_pin_oe_n, reset_pin_out}, 2'b00);
		check(data_pullup_en, 1'b1);
		reset_n = 1'b1;
		n = 0;
		while (module_reset !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		check(module_reset, 1'b1);
		check(master_reset_line, 1'b1);
		to_run(lo, rl);
		check(lo + n >= LOCK + DRV, 1'b1);
		check(rl >= REL, 1'b1);
		check(cfg, exp_cfg(~16'h0925, 1'b1, 2'b10));
		check(boot_base_addr, 24'h000000);
		n = 0;
		while (first_bus_cycle !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		check(n >= RSQ_FIRST_BUS - 1 && n <= RSQ_FIRST_BUS + 1, 1'b1);
		breakpoint_request = 2'b01;
		cyc(5);
		check({breakpoint_request_to_background, breakpoint_request_to_exception}, 2'b10);
		breakpoint_request = 2'b11;
		// Short internal request still gets the full drive period
		pull_low = 16'h0202;
		int_reset_req = 1'b1;
		cyc(3);
		int_reset_req = 1'b0;
		n = 0;
		while (reset_pin_oe_n !== 1'b0 && n < 10) begin
			cyc(1);
			n++;
		end
		check(reset_pin_oe_n, 1'b0);
		to_run(lo, rl);
		check(lo >= DRV, 1'b1);
		check(rl >= REL, 1'b1);
		check(cfg, exp_cfg(~16'h0202, 1'b1, 2'b11));
		// Long internal request holds the pin past the minimum
		int_reset_req = 1'b1;
		cyc(3 * DRV);
		check(reset_pin_oe_n, 1'b0);
		int_reset_req = 1'b0;
		to_run(lo, rl);
		check(lo >= 1 && lo <= 4, 1'b1);
		check(boot_cs_active, 1'b1);
		// External hold across several test windows
		pull_low = 16'h0000;
		ext_hold = 1'b1;
		cyc(3 * (DRV + REL));
		check(boot_cs_active, 1'b0);
		ext_hold = 1'b0;
		to_run(lo, rl);
		check(cfg, exp_cfg(16'hFFFF, 1'b1, 2'b11));
		breakpoint_request = 2'b10;
		cyc(5);
		check({breakpoint_request_to_background, breakpoint_request_to_exception}, 2'b01);
		breakpoint_request = 2'b11;
		// Three-state in clock-synthesiser mode is sticky
		three_state_control = 1'b1;
		n = 0;
		while (outputs_hiz !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		check(n >= RSQ_TSC_CYC - 1 && n < 20, 1'b1);
		three_state_control = 1'b0;
		int_reset_req = 1'b1;
		cyc(40);
		int_reset_req = 1'b0;
		cyc(40);
		check(outputs_hiz, 1'b1);
		// Power down, restart in external clock mode
		reset_n = 1'b0;
		clock_mode_select = 1'b0;
		cyc(16);
		reset_n = 1'b1;
		to_run(lo, rl);
		check(cfg.clk_from_vco, 1'b0);
		check(outputs_hiz, 1'b0);
		three_state_control = 1'b1;
		cyc(30);
		check(outputs_hiz, 1'b0);
		osc_run = 1'b1;
		cyc(60);
		check(outputs_hiz, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
